// [slcs_regs.svh]
// Constants of the status lamp and configuration store block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SLCS_REGS_SVH
`define SLCS_REGS_SVH

// System clock period in ns
`define SLCS_CLK_PERIOD_NS 10
// Half period of the fault lamp flash, in ms
`define SLCS_FLASH_HALF_MS 250
// Flash half period in clock cycles, derived from the two above
`define SLCS_FLASH_HALF_CYC (`SLCS_FLASH_HALF_MS * 1000000 / `SLCS_CLK_PERIOD_NS)
// Synchroniser depth for pin inputs
`define SLCS_SYNC_DEPTH 2
// Reset values
`define SLCS_RST_LAMP 1'b0
`define SLCS_RST_REQ 1'b0
// Positions inside the synchronised pin vector
`define SLCS_PIN_PLUG_PRESENT 0
`define SLCS_PIN_PLUG_BLANK 1
`define SLCS_PIN_PLUG_COMPAT 2
`define SLCS_PIN_PLUG_SAME 3
`define SLCS_PIN_ETH 4
`define SLCS_PIN_SUPPLY 8

`endif

// [slcs_pkg.sv]
// Types shared by the status lamp and configuration store block.
// Assumes slcs_regs.svh is on the include path.
`default_nettype none
`include "slcs_regs.svh"
package slcs_pkg;

	// Store sequencer states
	typedef enum logic [2:0] {
		ST_BOOT,
		ST_SAMPLE,
		ST_DECIDE,
		ST_BUSY,
		ST_ERR,
		ST_RUN
	} slcs_state_t;

	// Operations handed to the store copy engine
	typedef enum logic [2:0] {
		OP_NONE,
		OP_INT_TO_PLUG,
		OP_USE_PLUG,
		OP_ERASE_INT,
		OP_DEFAULTS_TO_PLUG,
		OP_CHANGE_TO_PLUG
	} slcs_op_t;

endpackage
`default_nettype wire

// [slcs_line_if.sv]
// Carrier between the top module and one line's lamp logic.
// Assumes all inputs are already on sys_clk.
`default_nettype none
interface slcs_line_if;
	logic prot;        // Protected mode (else configuration mode)
	logic diag;        // Entering diagnostic interrupt raised
	logic supply_low;  // Synchronised supply monitor
	logic missing;     // Configured slave missing
	logic extra;       // Unconfigured slave present
	logic differs;     // I/O config or ID code differs
	logic offline;     // Line offline
	logic autoprog;    // Replacement slave addressable
	logic frames;      // Master sending frames
	logic io_cfg;      // I/O modules configured
	logic fault_l;
	logic pwr_l;
	logic cer_l;
	logic aup_l;
	logic cm_l;
	logic on_l;
	logic act_all;

	modport ctl (
		output prot, diag, supply_low, missing, extra, differs,
		output offline, autoprog, frames, io_cfg,
		input  fault_l, pwr_l, cer_l, aup_l, cm_l, on_l, act_all
	);
	modport line (
		input  prot, diag, supply_low, missing, extra, differs,
		input  offline, autoprog, frames, io_cfg,
		output fault_l, pwr_l, cer_l, aup_l, cm_l, on_l, act_all
	);
endinterface
`default_nettype wire

// [slcs_line.sv]
// Lamp logic of one field line.
// Assumes all interface inputs are on sys_clk.
`default_nettype none
module slcs_line
	import slcs_pkg::*;
(
	input  wire logic sys_clk,  // System clock
	input  wire logic rst,      // Async reset, high
	slcs_line_if.line lif       // Line conditions and lamps
);

	typedef struct packed {
		logic fault_l;
		logic pwr_l;
		logic cer_l;
		logic aup_l;
		logic cm_l;
		logic on_l;
		logic act_all;
	} slcs_line_state_t;

	slcs_line_state_t q_reg;
	slcs_line_state_t q_next;

	always_comb begin
		q_next = q_reg;
		q_next.fault_l = lif.prot & lif.diag;
		q_next.pwr_l = lif.supply_low;
		q_next.cer_l = lif.missing | lif.extra | lif.differs
			| lif.offline;
		q_next.aup_l = lif.prot & lif.autoprog;
		q_next.cm_l = ~lif.prot;
		// Configuration mode brings every present slave up
		q_next.act_all = ~lif.prot;
		q_next.on_l = lif.frames & ~lif.offline & lif.io_cfg;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	assign lif.fault_l = q_reg.fault_l;
	assign lif.pwr_l = q_reg.pwr_l;
	assign lif.cer_l = q_reg.cer_l;
	assign lif.aup_l = q_reg.aup_l;
	assign lif.cm_l = q_reg.cm_l;
	assign lif.on_l = q_reg.on_l;
	assign lif.act_all = q_reg.act_all;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	line_fault_a: assert property (
		!$past(rst) |-> lif.fault_l == $past(lif.prot && lif.diag))
		else $error("line fault lamp wrong");
	aup_prot_a: assert property (
		!$past(lif.prot) |-> !lif.aup_l)
		else $error("auto address lamp lit outside protected mode");
	mode_lamp_a: assert property (
		!$past(rst) |-> lif.cm_l == lif.act_all
			&& lif.cm_l == !$past(lif.prot))
		else $error("mode lamp or activation wrong");
	online_off_a: assert property (
		($past(lif.offline) || !$past(lif.io_cfg)) |-> !lif.on_l)
		else $error("online lamp lit while offline or unconfigured");
	mismatch_on_a: assert property (
		!$past(rst) && $past(lif.offline || lif.missing) |-> lif.cer_l)
		else $error("mismatch lamp dark");

endmodule
`default_nettype wire

// [slcs_top.sv]
// Configuration store sequencer and front-panel lamp driver.
// Assumes a copy engine answers each request with op_done, and
// firmware keeps foreign_boot across power cycles.
//
// Summary of operation
// - Empty store found at start-up receives the internal configuration.
// - With a store present, each configuration change is also written to it.
// - A store from a compatible type supplies the configuration in use.
// - A store from a different type raises an error and an error state.
// - Operator ack ends the error and copies internal memory to the store.
// - Another unit's store is used; internal copy only on manual request.
// - Following a foreign-store boot, the next boot erases internal memory.
// - Factory reset with a store present also writes defaults to it.
// - Device fault lamp: protected-mode entering diagnostic, internal error.
// - Bus fault lamp flashes on lost or idle controller or bad parameters.
// - Line fault lamp lit on entering diagnostic in protected mode.
// - Line power-fail lamp follows the line supply monitor.
// - Mismatch lamp on missing, extra, differing slave, or line offline.
// - Auto-address lamp only in protected mode while replacement possible.
// - Mode lamp on in configuration mode, off in protected mode.
// - Configuration mode activates and exchanges data with all slaves.
// - Online lamp while frames are sent; off offline or unconfigured.
// - Each Ethernet port shows a link lamp and an activity lamp.
`default_nettype none
`include "slcs_regs.svh"
module slcs_top
	import slcs_pkg::*;
#(
	parameter int NUM_LINES      = 2,
	parameter int FLASH_HALF_CYC = `SLCS_FLASH_HALF_CYC
) (
	input  wire logic                 sys_clk,            // 100 MHz clock
	input  wire logic                 rst,                // Async reset, high
	input  wire logic                 start_up,           // Boot begins, pulse
	input  wire logic                 plug_present_pin,   // Store inserted
	input  wire logic                 plug_blank_pin,     // Store is empty
	input  wire logic                 plug_compat_pin,    // Compatible type
	input  wire logic                 plug_same_unit_pin, // Written by us
	input  wire logic                 prev_boot_foreign,  // Kept from last boot
	input  wire logic                 config_changed,     // Change, pulse
	input  wire logic                 factory_reset,      // Reset, pulse
	input  wire logic                 manual_copy,        // Copy req, pulse
	input  wire logic                 error_ack,          // Operator ack
	input  wire logic                 op_done,            // Engine done, pulse
	output logic                      op_req,             // Request level
	output slcs_op_t                  op_code,            // Requested op
	output logic                      store_error,        // Wrong type
	output logic                      foreign_boot,       // Runs other data
	output logic                      boot_done,          // Sequencer running
	input  wire logic                 dev_protected,      // Protected mode
	input  wire logic                 dev_diag_entering,  // Diag raised
	input  wire logic                 internal_error,     // Internal error
	input  wire logic                 ctrl_lost,          // Link to ctrl lost
	input  wire logic                 ctrl_inactive,      // Ctrl not active
	input  wire logic                 param_fault,        // Params missing/bad
	output logic                      system_fault_lamp,  // Device fault
	output logic                      fieldbus_fault_lamp, // Bus fault, flash
	input  wire logic                 ethernet_port_a_link_pin, // Link
	input  wire logic                 ethernet_port_a_act_pin,  // Traffic
	input  wire logic                 ethernet_port_b_link_pin, // Link
	input  wire logic                 ethernet_port_b_act_pin,  // Traffic
	output logic                      ethernet_port_a_link_lamp, // Link
	output logic                      ethernet_port_a_act_lamp,  // Traffic
	output logic                      ethernet_port_b_link_lamp, // Link
	output logic                      ethernet_port_b_act_lamp,  // Traffic
	input  wire logic [NUM_LINES-1:0] line_protected,     // Protected mode
	input  wire logic [NUM_LINES-1:0] line_diag_entering, // Diag raised
	input  wire logic [NUM_LINES-1:0] line_supply_low_pin, // Supply bad
	input  wire logic [NUM_LINES-1:0] line_slave_missing, // Slave missing
	input  wire logic [NUM_LINES-1:0] line_slave_extra,   // Slave extra
	input  wire logic [NUM_LINES-1:0] line_slave_differs, // Slave differs
	input  wire logic [NUM_LINES-1:0] line_offline,       // Line offline
	input  wire logic [NUM_LINES-1:0] line_autoprog_ok,   // Autoprog possible
	input  wire logic [NUM_LINES-1:0] line_frames_sent,   // Frames sent
	input  wire logic [NUM_LINES-1:0] line_io_configured, // I/O configured
	output wire logic [NUM_LINES-1:0] line_fault_lamp,    // Line fault
	output wire logic [NUM_LINES-1:0] line_power_fail_lamp, // Power fail
	output wire logic [NUM_LINES-1:0] config_mismatch_lamp, // Mismatch
	output wire logic [NUM_LINES-1:0] auto_address_lamp,  // Autoprog
	output wire logic [NUM_LINES-1:0] config_mode_lamp,   // Config mode
	output wire logic [NUM_LINES-1:0] line_online_lamp,   // Online
	output wire logic [NUM_LINES-1:0] line_activate_all   // Activate slaves
);

	localparam int PW = `SLCS_PIN_SUPPLY + NUM_LINES;
	localparam int CW = $clog2(FLASH_HALF_CYC + 1);
	localparam logic [CW-1:0] FLASH_LAST = CW'(FLASH_HALF_CYC - 1);

	typedef struct packed {
		slcs_state_t st;
		slcs_op_t    op;
		logic        op_req;
		logic        store_err;
		logic        foreign_boot;
		logic        boot_done;
		logic        change_pend;
		logic [3:0]  plug;
		logic [PW-1:0] s1;
		logic [PW-1:0] s2;
		logic        sys_fault;
		logic        bus_fault;
		logic        flash;
		logic [CW-1:0] fcnt;
		logic [3:0]  eth;
	} slcs_top_state_t;

	slcs_top_state_t q_reg;
	slcs_top_state_t q_next;

	logic [PW-1:0] pin_vec;
	logic          plug_in;
	logic          plug_blank;
	logic          plug_compat;
	logic          plug_same;
	logic          bus_cond;

	assign pin_vec = {line_supply_low_pin,
		ethernet_port_b_act_pin, ethernet_port_b_link_pin,
		ethernet_port_a_act_pin, ethernet_port_a_link_pin,
		plug_same_unit_pin, plug_compat_pin,
		plug_blank_pin, plug_present_pin};

	// Store facts as latched at start-up, not the live pins
	assign plug_in = q_reg.plug[`SLCS_PIN_PLUG_PRESENT];
	assign plug_blank = q_reg.plug[`SLCS_PIN_PLUG_BLANK];
	assign plug_compat = q_reg.plug[`SLCS_PIN_PLUG_COMPAT];
	assign plug_same = q_reg.plug[`SLCS_PIN_PLUG_SAME];
	assign bus_cond = ctrl_lost | ctrl_inactive | param_fault;

	always_comb begin
		q_next = q_reg;
		q_next.s1 = pin_vec;
		q_next.s2 = q_reg.s1;
		// A change seen during a busy copy is kept, set wins over clear
		if (config_changed && plug_in) begin
			q_next.change_pend = 1'b1;
		end
		unique case (q_reg.st)
			ST_BOOT: begin
				if (start_up) begin
					q_next.st = ST_SAMPLE;
					q_next.boot_done = 1'b0;
				end
			end
			ST_SAMPLE: begin
				// Store can only change while unpowered
				q_next.plug = q_reg.s2[3:0];
				q_next.foreign_boot = 1'b0;
				if (prev_boot_foreign) begin
					q_next.op = OP_ERASE_INT;
					q_next.op_req = 1'b1;
					q_next.st = ST_BUSY;
				end else begin
					q_next.st = ST_DECIDE;
				end
			end
			ST_DECIDE: begin
				if (!plug_in) begin
					q_next.st = ST_RUN;
				end else if (plug_blank) begin
					q_next.op = OP_INT_TO_PLUG;
					q_next.op_req = 1'b1;
					q_next.st = ST_BUSY;
				end else if (plug_compat) begin
					q_next.op = OP_USE_PLUG;
					q_next.op_req = 1'b1;
					q_next.foreign_boot = ~plug_same;
					q_next.st = ST_BUSY;
				end else begin
					q_next.store_err = 1'b1;
					q_next.st = ST_ERR;
				end
			end
			ST_ERR: begin
				if (error_ack) begin
					q_next.store_err = 1'b0;
					q_next.op = OP_INT_TO_PLUG;
					q_next.op_req = 1'b1;
					q_next.st = ST_BUSY;
				end
			end
			ST_BUSY: begin
				if (op_done) begin
					q_next.op_req = 1'b0;
					q_next.st = (q_reg.op == OP_ERASE_INT) ? ST_DECIDE
						: ST_RUN;
					q_next.op = OP_NONE;
				end
			end
			ST_RUN: begin
				q_next.boot_done = 1'b1;
				if (start_up) begin
					q_next.st = ST_SAMPLE;
					q_next.boot_done = 1'b0;
				end else if (plug_in && factory_reset) begin
					q_next.op = OP_DEFAULTS_TO_PLUG;
					q_next.op_req = 1'b1;
					q_next.change_pend = config_changed & plug_in;
					q_next.st = ST_BUSY;
				end else if (plug_in && manual_copy) begin
					q_next.op = OP_INT_TO_PLUG;
					q_next.op_req = 1'b1;
					q_next.st = ST_BUSY;
				end else if (q_reg.change_pend && plug_in) begin
					q_next.op = OP_CHANGE_TO_PLUG;
					q_next.op_req = 1'b1;
					q_next.change_pend = config_changed & plug_in;
					q_next.st = ST_BUSY;
				end
			end
		endcase
		q_next.sys_fault = (dev_protected & dev_diag_entering)
			| internal_error;
		// Free-running flash that gates the bus fault lamp; other fault lamps are steady
		if (q_reg.fcnt == FLASH_LAST) begin
			q_next.fcnt = '0;
			q_next.flash = ~q_reg.flash;
		end else begin
			q_next.fcnt = q_reg.fcnt + CW'(1);
		end
		q_next.bus_fault = bus_cond & q_reg.flash;
		q_next.eth = q_reg.s2[`SLCS_PIN_ETH +: 4];
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	assign op_req = q_reg.op_req;
	assign op_code = q_reg.op;
	assign store_error = q_reg.store_err;
	assign foreign_boot = q_reg.foreign_boot;
	assign boot_done = q_reg.boot_done;
	assign system_fault_lamp = q_reg.sys_fault;
	assign fieldbus_fault_lamp = q_reg.bus_fault;
	assign ethernet_port_a_link_lamp = q_reg.eth[0];
	assign ethernet_port_a_act_lamp = q_reg.eth[1];
	assign ethernet_port_b_link_lamp = q_reg.eth[2];
	assign ethernet_port_b_act_lamp = q_reg.eth[3];

	for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
		slcs_line_if lif ();
		assign lif.prot = line_protected[g];
		assign lif.diag = line_diag_entering[g];
		assign lif.supply_low = q_reg.s2[`SLCS_PIN_SUPPLY + g];
		assign lif.missing = line_slave_missing[g];
		assign lif.extra = line_slave_extra[g];
		assign lif.differs = line_slave_differs[g];
		assign lif.offline = line_offline[g];
		assign lif.autoprog = line_autoprog_ok[g];
		assign lif.frames = line_frames_sent[g];
		assign lif.io_cfg = line_io_configured[g];
		assign line_fault_lamp[g] = lif.fault_l;
		assign line_power_fail_lamp[g] = lif.pwr_l;
		assign config_mismatch_lamp[g] = lif.cer_l;
		assign auto_address_lamp[g] = lif.aup_l;
		assign config_mode_lamp[g] = lif.cm_l;
		assign line_online_lamp[g] = lif.on_l;
		assign line_activate_all[g] = lif.act_all;
		slcs_line u_slcs_line (
			.sys_clk (sys_clk),
			.rst     (rst),
			.lif     (lif.line)
		);
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_decide_plug;
		q_reg.st == ST_DECIDE && plug_in;
	endsequence

	blank_copy_a: assert property (
		s_decide_plug and (plug_blank) |=> op_req
			&& op_code == OP_INT_TO_PLUG ##1 op_req)
		else $error("empty store not filled");
	change_write_a: assert property (
		q_reg.st == ST_RUN && q_reg.change_pend && plug_in && !start_up
			&& !factory_reset && !manual_copy
			|=> op_req && op_code == OP_CHANGE_TO_PLUG)
		else $error("change not written to store");
	compat_use_a: assert property (
		s_decide_plug and (!plug_blank && plug_compat)
			|=> op_code == OP_USE_PLUG && foreign_boot == !plug_same)
		else $error("compatible store not used");
	wrong_type_a: assert property (
		s_decide_plug and (!plug_blank && !plug_compat)
			|=> store_error && !op_req)
		else $error("wrong type store not flagged");
	ack_copy_a: assert property (
		store_error && error_ack
			|=> !store_error && op_code == OP_INT_TO_PLUG)
		else $error("ack did not start copy");
	manual_only_a: assert property (
		$rose(op_req) && op_code == OP_INT_TO_PLUG
			&& $past(q_reg.st) == ST_RUN |-> $past(manual_copy))
		else $error("internal copy without request");
	erase_boot_a: assert property (
		q_reg.st == ST_SAMPLE && prev_boot_foreign
			|=> op_req && op_code == OP_ERASE_INT)
		else $error("erase not issued at boot");
	factory_a: assert property (
		q_reg.st == ST_RUN && plug_in && factory_reset && !start_up
			|=> op_code == OP_DEFAULTS_TO_PLUG)
		else $error("defaults not written to store");
	sys_fault_a: assert property (
		internal_error |=> system_fault_lamp)
		else $error("device fault lamp dark");
	bus_flash_a: assert property (
		!bus_cond |=> !fieldbus_fault_lamp)
		else $error("bus lamp lit without cause");
	eth_link_a: assert property (
		!$past(rst) && !$past(rst, 2) && !$past(rst, 3) |->
		ethernet_port_a_link_lamp == $past(ethernet_port_a_link_pin, 3))
		else $error("port a link lamp wrong");
	power_fail_a: assert property (
		!$past(rst) && !$past(rst, 2) && !$past(rst, 3) |->
		line_power_fail_lamp[0] == $past(line_supply_low_pin[0], 3))
		else $error("power fail lamp wrong");
	plug_frozen_a: assert property (
		q_reg.st != ST_SAMPLE |=> $stable(q_reg.plug))
		else $error("store sampled outside start-up");

endmodule
`default_nettype wire

// [slcs_engine_model.sv]
// Behavioural store copy engine facing the sequencer.
// Assumes op_req is a level held until op_done is sampled.
`default_nettype none
module slcs_engine_model (
	input  wire logic sys_clk, // System clock
	input  wire logic rst,     // Async reset, high
	input  wire logic op_req,  // Request level
	output var  logic op_done  // Done, one cycle
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned wait_cyc;

	initial op_done = 1'b0;

	// Random stall so both prompt and slow answers occur
	always begin
		@(posedge sys_clk);
		if (op_req === 1'b1 && rst === 1'b0) begin
			wait_cyc = $urandom_range(6, 0);
			repeat (wait_cyc) @(posedge sys_clk);
			#1 op_done = 1'b1;
			@(posedge sys_clk);
			#1 op_done = 1'b0;
			// Request drops one cycle after done; skip that cycle
			@(posedge sys_clk);
		end
	end
endmodule
`default_nettype wire

// [tb_status_led_and_config_store.sv]
// Self-checking bench of the store sequencer and lamps.
// Assumes slcs_pkg is compiled first; short flash period.
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin \
	$display("Error %s expected %0h seen %0h", nm, e, g); \
	mismatches++; end end
module tb_status_led_and_config_store
	import slcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		int          due;
		logic [19:0] v;
		logic [19:0] m;
	} slcs_note_t;
	logic         sys_clk = 1'b0;
	logic         rst = 1'b1;
	logic         start_up, config_changed, factory_reset, manual_copy;
	logic         error_ack, prev_boot_foreign;
	logic [3:0]   plug, eth_pin, eth_lamp;
	wire logic    op_done;
	logic         op_req, store_error, foreign_boot, boot_done;
	slcs_op_t     op_code;
	logic         dprot, ddiag, ierr, c_lost, c_idle, p_bad, sf_l, fb_l;
	logic [1:0]   l_prot, l_diag, l_sup, l_miss, l_ext, l_dif, l_off;
	logic [1:0]   l_auto, l_frm, l_io;
	logic [1:0]   o_flt, o_pwr, o_cer, o_aup, o_cm, o_on, o_act;
	int           mismatches = 0;
	int           n_checks = 0;
	int           cyc = 0;
	logic         req_q = 1'b0;
	logic         done_q = 1'b0;
	slcs_op_t     op_q[$];
	slcs_note_t   lamp_q[$];
	slcs_note_t   nt;
	logic [31:0]  r;
	int           hi;
	slcs_op_t     exp_op;
	slcs_note_t   got;
	logic [19:0]  seen;

	always #5 sys_clk = ~sys_clk;

	slcs_top #(.NUM_LINES(2), .FLASH_HALF_CYC(4)) u_slcs_top (
		.sys_clk(sys_clk), .rst(rst), .start_up(start_up),
		.plug_present_pin(plug[3]), .plug_blank_pin(plug[2]),
		.plug_compat_pin(plug[1]), .plug_same_unit_pin(plug[0]),
		.prev_boot_foreign(prev_boot_foreign),
		.config_changed(config_changed), .factory_reset(factory_reset),
		.manual_copy(manual_copy), .error_ack(error_ack),
		.op_done(op_done), .op_req(op_req), .op_code(op_code),
		.store_error(store_error), .foreign_boot(foreign_boot),
		.boot_done(boot_done), .dev_protected(dprot),
		.dev_diag_entering(ddiag), .internal_error(ierr),
		.ctrl_lost(c_lost), .ctrl_inactive(c_idle), .param_fault(p_bad),
		.system_fault_lamp(sf_l), .fieldbus_fault_lamp(fb_l),
		.ethernet_port_a_link_pin(eth_pin[3]),
		.ethernet_port_a_act_pin(eth_pin[2]),
		.ethernet_port_b_link_pin(eth_pin[1]),
		.ethernet_port_b_act_pin(eth_pin[0]),
		.ethernet_port_a_link_lamp(eth_lamp[3]),
		.ethernet_port_a_act_lamp(eth_lamp[2]),
		.ethernet_port_b_link_lamp(eth_lamp[1]),
		.ethernet_port_b_act_lamp(eth_lamp[0]),
		.line_protected(l_prot), .line_diag_entering(l_diag),
		.line_supply_low_pin(l_sup), .line_slave_missing(l_miss),
		.line_slave_extra(l_ext), .line_slave_differs(l_dif),
		.line_offline(l_off), .line_autoprog_ok(l_auto),
		.line_frames_sent(l_frm), .line_io_configured(l_io),
		.line_fault_lamp(o_flt), .line_power_fail_lamp(o_pwr),
		.config_mismatch_lamp(o_cer), .auto_address_lamp(o_aup),
		.config_mode_lamp(o_cm), .line_online_lamp(o_on),
		.line_activate_all(o_act));

	slcs_engine_model u_slcs_engine_model (.sys_clk(sys_clk), .rst(rst),
		.op_req(op_req), .op_done(op_done));

	task automatic print_verdict();
		if (mismatches == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// A new request is a rise, or a level right after a done
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		req_q <= op_req;
		done_q <= op_done;
		if (op_req === 1'b1 && (req_q !== 1'b1 || done_q === 1'b1)) begin
			if (op_q.size() == 0)
				`CHK("unexpected op_code", OP_NONE, op_code)
			else begin
				// Pop once; the macro repeats its arguments
				exp_op = op_q.pop_front();
				`CHK("op_code", exp_op, op_code)
			end
		end
		if (lamp_q.size() > 0 && lamp_q[0].due == cyc) begin
			got = lamp_q.pop_front();
			seen = {sf_l, fb_l, eth_lamp, o_flt, o_pwr, o_cer, o_aup, o_cm,
				o_on, o_act};
			`CHK("lamps", got.v, got.m & seen)
		end
	end

	task automatic tick(input int n = 1);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic pulse(input int k);
		case (k)
			0: start_up = 1'b1;
			1: config_changed = 1'b1;
			2: factory_reset = 1'b1;
			3: manual_copy = 1'b1;
			default: error_ack = 1'b1;
		endcase
		tick();
		{start_up, config_changed, factory_reset, manual_copy} = 4'h0;
		error_ack = 1'b0;
	endtask

	task automatic settle();
		int i;
		for (i = 0; i < 300; i++) begin
			if (op_q.size() == 0 && op_req === 1'b0 &&
				(boot_done === 1'b1 || store_error === 1'b1))
				break;
			tick();
		end
		if (i == 300) begin
			mismatches++;
			$display("Error settle expected idle seen timeout");
			print_verdict();
		end
		tick(2);
	endtask

	// Pins: present, blank, compatible, same unit, previous foreign
	task automatic boot(input logic [4:0] p);
		{plug, prev_boot_foreign} = p;
		tick(3);
		pulse(0);
		tick(6);
		settle();
		prev_boot_foreign = 1'b0;
	endtask

	initial begin
		{start_up, config_changed, factory_reset, manual_copy} = 4'h0;
		{error_ack, prev_boot_foreign, plug, eth_pin} = 10'h000;
		{dprot, ddiag, ierr, c_lost, c_idle, p_bad} = 6'h00;
		{l_prot, l_diag, l_sup, l_miss, l_ext} = 10'h000;
		{l_dif, l_off, l_auto, l_frm, l_io} = 10'h000;
		r = $urandom(97);
		repeat (12) @(posedge sys_clk);
		#1 rst = 1'b0;
		tick();
		op_q.push_back(OP_INT_TO_PLUG);
		boot(5'h18);
		op_q.push_back(OP_CHANGE_TO_PLUG);
		op_q.push_back(OP_CHANGE_TO_PLUG);
		pulse(1);
		tick();
		pulse(1);
		settle();
		op_q.push_back(OP_DEFAULTS_TO_PLUG);
		pulse(2);
		settle();
		op_q.push_back(OP_USE_PLUG);
		boot(5'h16);
		`CHK("foreign_boot", 1'b0, foreign_boot)
		`CHK("boot_done", 1'b1, boot_done)
		op_q.push_back(OP_USE_PLUG);
		boot(5'h14);
		`CHK("foreign_boot", 1'b1, foreign_boot)
		op_q.push_back(OP_INT_TO_PLUG);
		pulse(3);
		settle();
		op_q.push_back(OP_ERASE_INT);
		op_q.push_back(OP_USE_PLUG);
		boot(5'h15);
		boot(5'h10);
		`CHK("store_error", 1'b1, store_error)
		pulse(3);
		tick(5);
		`CHK("store_error", 1'b1, store_error)
		op_q.push_back(OP_INT_TO_PLUG);
		pulse(4);
		settle();
		`CHK("store_error", 1'b0, store_error)
		// Store appearing after the sample is ignored
		boot(5'h00);
		plug = 4'hC;
		tick(4);
		pulse(3);
		tick();
		pulse(2);
		tick();
		pulse(1);
		tick(10);
		repeat (40) begin
			r = $urandom;
			{dprot, ddiag, ierr, c_lost, c_idle, p_bad, eth_pin} = r[9:0];
			{l_prot, l_diag, l_sup, l_miss, l_ext} = r[19:10];
			r = $urandom;
			{l_dif, l_off, l_auto, l_frm, l_io} = r[9:0];
			nt.due = cyc + 3;
			nt.m = {1'b1, ~(c_lost | c_idle | p_bad), 18'h3FFFF};
			nt.v = {(dprot & ddiag) | ierr, 1'b0, eth_pin, l_prot & l_diag,
				l_sup, l_miss | l_ext | l_dif | l_off, l_prot & l_auto,
				~l_prot, l_frm & ~l_off & l_io, ~l_prot};
			lamp_q.push_back(nt);
			tick(4);
		end
		for (int k = 0; k < 4; k++) begin
			{c_lost, c_idle, p_bad} = 3'h4 >> k;
			tick(3);
			hi = 0;
			repeat (32) begin
				tick();
				if (fb_l === 1'b1)
					hi++;
			end
			`CHK("flash highs", (k < 3) ? 16 : 0, hi)
		end
		print_verdict();
	end
endmodule
`default_nettype wire
